/* bench/rrex_exec_properties.sv */
`timescale 1ns/1ps
module rrex_exec_properties #(parameter int unsigned PC_W = 13) (
    input wire logic                    core_clk, rst_n, instr_valid,
    input wire rrex_pkg::rrex_instr_t   instr,
    input wire logic [7:0]              file_rd_data, acc,
    input wire logic [PC_W-1:0]         stack_head, pc_value,
    input wire logic                    instr_ready, stack_pop, flush, carry,
    input wire rrex_pkg::rrex_file_wr_t file_wr
);
    // Taken operations of each kind
    wire go = instr_valid && instr_ready;
    wire rt = go && instr.op == rrex_pkg::RREX_OP_RETURN;
    wire rw = go && instr.op == rrex_pkg::RREX_OP_RETURN_WITH_LITERAL;
    wire rl = go && instr.op == rrex_pkg::RREX_OP_ROTATE_LEFT_CARRY;
    wire rr = go && instr.op == rrex_pkg::RREX_OP_ROTATE_RIGHT_CARRY;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Flushed stall cycle, then ready again
    sequence s_stall; flush && !instr_ready ##1 instr_ready; endsequence
    chk_ret_pop: assert property (rt |=> stack_pop &&
        pc_value == $past(stack_head) && carry == $past(carry)) else $error("ret pop");
    chk_ret_two_cycles: assert property ((rt || rw) |=> s_stall)
        else $error("return length");
    chk_lit_acc: assert property (rw |=> acc == $past(instr.literal)
        && carry == $past(carry)) else $error("literal acc");
    chk_lit_pop: assert property (rw |=> stack_pop &&
        pc_value == $past(stack_head)) else $error("literal pop");
    chk_left_carry: assert property (rl |=>
        carry == $past(file_rd_data[7])) else $error("left carry");
    chk_right_carry: assert property (rr |=>
        carry == $past(file_rd_data[0])) else $error("right carry");
    chk_rot_dest: assert property ((rl || rr) && instr.dest |=>
        file_wr.we && acc == $past(acc) && file_wr.addr ==
        $past(instr.file_addr)) else $error("rotate dest");
    chk_rot_single: assert property ((rl || rr) |=>
        instr_ready && !stack_pop && !flush) else $error("rotate length");
endmodule : rrex_exec_properties
bind rrex_exec rrex_exec_properties #(.PC_W(PC_W)) rrex_props_i (.core_clk,
    .rst_n, .instr_valid, .instr, .file_rd_data, .acc, .stack_head,
    .pc_value, .instr_ready, .stack_pop, .flush, .carry, .file_wr);

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic                    core_clk, rst_n, instr_valid, carry_m, carry;
    logic                    instr_ready, stack_pop, pc_load, flush;
    rrex_pkg::rrex_instr_t   instr;
    rrex_pkg::rrex_file_wr_t file_wr;
    logic [7:0]              file_rd_data, acc, acc_m;
    logic [12:0]             stack_head, pc_value;
    logic [31:0]             r = 32'h0001_0046;
    logic [8:0]              e;
    int                      failures, check_count;
    rrex_exec rrex_exec_i (.core_clk, .rst_n, .instr_valid, .instr,
        .file_rd_data, .stack_head, .instr_ready, .stack_pop, .pc_load,
        .pc_value, .flush, .file_wr, .acc, .carry);
    // Core clock
    initial begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Carry out and result of a rotate
    function automatic logic [8:0] rot(input logic [7:0] d, input logic c,
        input logic left);
        return left ? {d, c} : {d[0], c, d[7:1]};
    endfunction : rot
    task automatic check(input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // Offer one operation, left offered through any stall
    task automatic issue(input logic [1:0] k, input logic [31:0] v);
        instr = {k + 3'd1, v[15:0]};
        file_rd_data = v[23:16];
        stack_head = v[31:19];
        e = rot(v[23:16], carry_m, k == 2'd2);
        @(posedge core_clk);
        #1;
        if (k < 2'd2) begin
            acc_m = k[0] ? v[15:8] : acc_m;
            check(pc_value, v[31:19]);
            check({stack_pop, pc_load, flush, instr_ready}, 4'hE);
            @(posedge core_clk);
            #1;
            check({instr_ready, stack_pop}, 2'b10);
        end else begin
            carry_m = e[8];
            acc_m = v[0] ? acc_m : e[7:0];
            check(file_wr.we, v[0]);
            if (v[0])
                check(file_wr, {1'b1, v[7:1], e[7:0]});
            check({stack_pop, instr_ready}, 2'b01);
        end
        check(acc, acc_m);
        check(carry, carry_m);
    endtask : issue
    // Reset, corners, then random traffic
    initial begin
        {rst_n, instr_valid, instr, file_rd_data, stack_head} = '0;
        acc_m = rrex_pkg::ACC_RESET;
        carry_m = rrex_pkg::CARRY_RESET;
        repeat (4) @(posedge core_clk);
        #1;
        rst_n = 1;
        instr_valid = 1;
        issue(2'd2, 32'h0080_0000);
        issue(2'd3, 32'h0001_0001);
        issue(2'd1, 32'h0000_FF00);
        repeat (300) begin
            r = lfsr(r);
            issue(r[26:25], r);
        end
        end_of_test();
    end
    // Watchdog
    initial begin
        repeat (2000) @(posedge core_clk);
        failures++;
        end_of_test();
    end
endmodule : testbench

/* common/rrex_pkg.sv */
package rrex_pkg;

    // Instruction cycles per operation
    localparam int unsigned RET_CYCLES = 2;
    localparam int unsigned ROT_CYCLES = 1;

    // Reset values of core state held here
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic        CARRY_RESET = 1'b0;

    // Destination select encoding
    localparam logic        DEST_ACC    = 1'b0;
    localparam logic        DEST_FILE   = 1'b1;

    // Operations offered by the decoder
    typedef enum logic [2:0] {
        RREX_OP_NONE,
        RREX_OP_RETURN,
        RREX_OP_RETURN_WITH_LITERAL,
        RREX_OP_ROTATE_LEFT_CARRY,
        RREX_OP_ROTATE_RIGHT_CARRY
    } rrex_op_t;

    // One decoded instruction
    typedef struct packed {
        rrex_op_t   op;
        logic [7:0] literal;
        logic [6:0] file_addr;
        logic       dest;
    } rrex_instr_t;

    // Write back to the file register space
    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } rrex_file_wr_t;

endpackage : rrex_pkg

/* rtl/rrex_exec.sv */
`timescale 1ns/1ps
module rrex_exec #(
    parameter int unsigned PC_W = 13
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  instr_valid,
    input  wire rrex_pkg::rrex_instr_t instr,
    input  wire logic [7:0]            file_rd_data,
    input  wire logic [PC_W-1:0]       stack_head,
    output logic                       instr_ready,
    output logic                       stack_pop,
    output logic                       pc_load,
    output logic [PC_W-1:0]            pc_value,
    output logic                       flush,
    output rrex_pkg::rrex_file_wr_t    file_wr,
    output logic [7:0]                 acc,
    output logic                       carry
);

    // Control states of the return sequence
    typedef enum logic {
        RREX_IDLE,
        RREX_REFETCH
    } rrex_state_t;

    // Stall counter sized for the return length
    localparam int unsigned        STALL_W    = 2;
    localparam logic [STALL_W-1:0] STALL_LOAD =
        STALL_W'(rrex_pkg::RET_CYCLES - 1);
    localparam logic [STALL_W-1:0] STALL_ONE  = STALL_W'(1);

    // Control group state
    rrex_state_t             state_q;
    rrex_state_t             state_d;
    logic [STALL_W-1:0]      stall_q;
    logic [STALL_W-1:0]      stall_d;
    logic                    ready_q;
    logic                    ready_d;
    logic                    pop_q;
    logic                    pop_d;
    logic                    pc_load_q;
    logic                    pc_load_d;
    logic [PC_W-1:0]         pc_q;
    logic [PC_W-1:0]         pc_d;
    logic                    flush_q;
    logic                    flush_d;

    // Data group state
    rrex_pkg::rrex_file_wr_t fwr_q;
    rrex_pkg::rrex_file_wr_t fwr_d;
    logic [7:0]              acc_q;
    logic [7:0]              acc_d;
    logic                    carry_q;
    logic                    carry_d;

    // Decode and rotate datapath
    logic                    take;
    logic                    is_plain_ret;
    logic                    is_lit_ret;
    logic                    is_ret;
    logic                    is_left;
    logic                    is_right;
    logic                    is_rot;
    logic [7:0]              rot_left_v;
    logic [7:0]              rot_right_v;
    logic [7:0]              rot_res;
    logic                    rot_carry;

    // Instruction taken only while idle and ready
    assign take         = instr_valid && ready_q
                          && (state_q == RREX_IDLE);
    assign is_plain_ret = (instr.op == rrex_pkg::RREX_OP_RETURN);
    assign is_lit_ret   =
        (instr.op == rrex_pkg::RREX_OP_RETURN_WITH_LITERAL);
    assign is_ret       = is_plain_ret || is_lit_ret;
    assign is_left      =
        (instr.op == rrex_pkg::RREX_OP_ROTATE_LEFT_CARRY);
    assign is_right     =
        (instr.op == rrex_pkg::RREX_OP_ROTATE_RIGHT_CARRY);
    assign is_rot       = is_left || is_right;

    // Per-bit rotate, end bits take the old carry
    for (genvar b = 0; b < 8; b++) begin : g_rot
        if (b == 0) begin : g_left_end
            assign rot_left_v[b] = carry_q;
        end else begin : g_left_mid
            assign rot_left_v[b] = file_rd_data[b-1];
        end
        if (b == 7) begin : g_right_end
            assign rot_right_v[b] = carry_q;
        end else begin : g_right_mid
            assign rot_right_v[b] = file_rd_data[b+1];
        end
    end

    // Pick direction and the bit that leaves into carry
    assign rot_res   = is_left ? rot_left_v : rot_right_v;
    assign rot_carry = is_left ? file_rd_data[7]
                               : file_rd_data[0];

    // Control next values: pop, load PC, then stall for refetch
    always_comb begin
        state_d   = state_q;
        stall_d   = stall_q;
        ready_d   = ready_q;
        pop_d     = 1'b0;
        pc_load_d = 1'b0;
        pc_d      = pc_q;
        flush_d   = 1'b0;
        unique case (state_q)
            RREX_IDLE: begin
                ready_d = 1'b1;
                if (take && is_ret) begin
                    pop_d     = 1'b1;
                    pc_load_d = 1'b1;
                    pc_d      = stack_head;
                    flush_d   = 1'b1;
                    ready_d   = 1'b0;
                    stall_d   = STALL_LOAD;
                    state_d   = RREX_REFETCH;
                end
            end
            RREX_REFETCH: begin
                // Slot spent while the fetch restarts
                stall_d = stall_q - STALL_ONE;
                if (stall_q == STALL_ONE) begin
                    state_d = RREX_IDLE;
                    ready_d = 1'b1;
                end
            end
        endcase
    end

    // Control registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= RREX_IDLE;
            stall_q   <= '0;
            ready_q   <= 1'b1;
            pop_q     <= 1'b0;
            pc_load_q <= 1'b0;
            pc_q      <= '0;
            flush_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            stall_q   <= stall_d;
            ready_q   <= ready_d;
            pop_q     <= pop_d;
            pc_load_q <= pc_load_d;
            pc_q      <= pc_d;
            flush_q   <= flush_d;
        end
    end

    // Data next values: returns never touch carry
    always_comb begin
        fwr_d   = '0;
        acc_d   = acc_q;
        carry_d = carry_q;
        if (take && is_lit_ret) begin
            acc_d = instr.literal;
        end
        if (take && is_rot) begin
            // Carry and result land in the same cycle
            carry_d = rot_carry;
            if (instr.dest == rrex_pkg::DEST_ACC) begin
                acc_d = rot_res;
            end else begin
                fwr_d.we   = 1'b1;
                fwr_d.addr = instr.file_addr;
                fwr_d.data = rot_res;
            end
        end
    end

    // Data registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fwr_q   <= '0;
            acc_q   <= rrex_pkg::ACC_RESET;
            carry_q <= rrex_pkg::CARRY_RESET;
        end else begin
            fwr_q   <= fwr_d;
            acc_q   <= acc_d;
            carry_q <= carry_d;
        end
    end

    // Outputs straight from flops
    assign instr_ready = ready_q;
    assign stack_pop   = pop_q;
    assign pc_load     = pc_load_q;
    assign pc_value    = pc_q;
    assign flush       = flush_q;
    assign file_wr     = fwr_q;
    assign acc         = acc_q;
    assign carry       = carry_q;

endmodule : rrex_exec
